// File: hw/pulse_batch_consts.vh
// pulse_batch_consts.vh: register offsets, field positions, limits, reset values and timing
// assumes inclusion by the batch controller and its bench; holds definitions and no logic
`ifndef PULSE_BATCH_CONSTS_VH
`define PULSE_BATCH_CONSTS_VH
// register byte offsets
`define REG_CTRL 8'h00
`define REG_SCALE 8'h04
`define REG_PRESET_A 8'h08
`define REG_PRESET_B 8'h0C
`define REG_PREWARN 8'h10
`define REG_ONTIME 8'h14
`define REG_RATE_WIN 8'h18
`define REG_LOCK 8'h1C
`define REG_UNLOCK 8'h20
`define REG_ACCESS 8'h24
`define REG_STATUS 8'h28
`define REG_AMOUNT 8'h2C
`define REG_SECOND 8'h30
`define REG_RATE 8'h34
`define REG_SERIAL 8'h38
// control fields
`define CTRL_DOWN 0
`define CTRL_AUX_LO 1
`define CTRL_AUX_HI 2
`define CTRL_SEC_SEL 3
`define CTRL_RU_LO 4
`define CTRL_RU_HI 5
`define CTRL_AN_SRC 6
`define CTRL_W 7
// scale divisor value low, decimal places above; lock open bit
`define SCALE_DP_LO 17
`define SCALE_DP_HI 19
`define LOCK_OPEN_BIT 17
// aux relay modes and rate units
`define AUX_PREWARN 2'h0
`define AUX_BATCHES 2'h1
`define AUX_GRAND 2'h2
`define RU_SEC 2'h0
`define RU_MIN 2'h1
`define RU_HOUR 2'h2
`define MULT_SEC 12'h001
`define MULT_MIN 12'h03C
`define MULT_HOUR 12'hE10
`define HUNDRED 7'h64
// serial config: unit address, bit rate code (0=300 .. 5=9600), parity (0 none, 1 odd, 2 even)
`define SER_ADDR_HI 7
`define SER_BAUD_LO 8
`define SER_BAUD_HI 10
`define SER_PAR_LO 11
`define SER_PAR_HI 12
`define SER_W 13
// limits
`define VAL_MAX 17'h1869F
`define DP_MAX 3'h4
`define ONTIME_MAX 14'h270F
`define WIN_MIN 5'h02
`define WIN_MAX 5'h18
`define ADDR_MIN 8'h01
`define ADDR_MAX 8'hF7
`define BAUD_MAX 3'h5
`define PAR_MAX 2'h2
`define RANGE_MAX 2'h2
`define DIV_STEPS 6'h2A
// reset values
`define CTRL_RST 7'h00
`define SCALE_RST 20'h00001
`define WIN_RST 5'h02
`define SER_RST 13'h0501
// timing
`define CLK_HZ 25000000
`define RATE_UPDATE_MS 1000
`define ONTIME_STEP_MS 10
`endif

// File: hw/pulse_batch_controller.v
// pulse_batch_controller.v: batch control core with AHB-Lite register slave
// assumes one clock hclk at 25 MHz; pins arrive asynchronously, nv store runs on hclk
`timescale 1ns/10ps
`include "pulse_batch_consts.vh"

module pulse_batch_controller #(
	parameter SEC_CYCLES = `CLK_HZ / 1000 * `RATE_UPDATE_MS,
	parameter STEP_CYCLES = `CLK_HZ / 1000 * `ONTIME_STEP_MS
) (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// ahb-lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata_r,
	output reg hreadyout_r,
	output reg hresp_r,
	// field pins
	input wire pulse_in,
	input wire start_in,
	input wire stop_front_in,
	input wire stop_remote_in,
	// outputs
	output reg relay_batch_r,
	output reg relay_aux_r,
	output reg [16:0] analog_value_r,
	// non-volatile serial settings
	input wire nv_load,
	input wire [12:0] nv_cfg_in,
	output reg [12:0] nv_cfg_out_r,
	output reg nv_store_r
);
	// terminal counts cut to the counter widths on purpose
	localparam integer SEC_LAST_I = SEC_CYCLES - 1;
	localparam integer STEP_LAST_I = STEP_CYCLES - 1;
	localparam [24:0] SEC_LAST = SEC_LAST_I[24:0];
	localparam [17:0] STEP_LAST = STEP_LAST_I[17:0];
	localparam RS_IDLE = 1'b0;
	localparam RS_DIV = 1'b1;

	function [16:0] pow10;
		input [2:0] dp;
		begin
			case (dp)
				3'h0: pow10 = 17'h00001;
				3'h1: pow10 = 17'h0000A;
				3'h2: pow10 = 17'h00064;
				3'h3: pow10 = 17'h003E8;
				default: pow10 = 17'h02710;
			endcase
		end
	endfunction

	reg [3:0] s1_r, s2_r, s3_r, filt_r, filt_d_r;
	reg [6:0] ctrl_r;
	reg [19:0] scale_r;
	reg [16:0] preset_a_r, preset_b_r, prewarn_r, lock_code_r;
	reg [13:0] ontime_r, aux_tmr_r;
	reg [4:0] win_r;
	reg lock_open_r, unlocked_r, remote_r;
	reg [12:0] serial_r;
	reg wr_pend_r;
	reg [7:0] wa_r;
	reg [16:0] residue_r, delivered_r, batches_r, grand_r, cur_cnt_r, rate_r;
	reg running_r, done_r;
	reg [17:0] step_cnt_r;
	reg [24:0] sec_cnt_r;
	reg [16:0] ring [0:23];
	reg [4:0] ptr_r, fill_r;
	reg [21:0] sum_r;
	reg rs_r;
	reg [41:0] num_r, quo_r;
	reg [12:0] rem_r;
	reg [11:0] dvs_r;
	reg [5:0] dstep_r;
	reg [1:0] rk_r, rate_dp_r;
	reg [31:0] rd_nxt;
	reg [11:0] mult;

	// pin filter: a level moves once stages two and three agree
	wire [3:0] agree = ~(s2_r ^ s3_r);
	wire [3:0] rise = filt_r & ~filt_d_r;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_r <= 4'h0;
			s2_r <= 4'h0;
			s3_r <= 4'h0;
			filt_r <= 4'h0;
			filt_d_r <= 4'h0;
		end else begin
			s1_r <= {stop_remote_in, stop_front_in, start_in, pulse_in};
			s2_r <= s1_r;
			s3_r <= s2_r;
			filt_r <= (agree & s3_r) | (~agree & filt_r);
			filt_d_r <= filt_r;
		end
	end

	// bus decode; zero wait states, so the read word is caught in the address phase
	wire acc = hsel & htrans[1] & hready;
	wire locked = (lock_code_r != 17'h0) & ~unlocked_r;
	wire cfg_ok = ~remote_r & ~locked;
	wire set_ok = remote_r | ~locked | lock_open_r;
	wire [1:0] aux_mode = ctrl_r[`CTRL_AUX_HI:`CTRL_AUX_LO];
	wire [16:0] sdiv = scale_r[16:0];
	wire [2:0] sdp = scale_r[`SCALE_DP_HI:`SCALE_DP_LO];
	wire [16:0] remain_down = (delivered_r >= preset_a_r) ? 17'h0 : preset_a_r - delivered_r;
	wire [16:0] amount = ctrl_r[`CTRL_DOWN] ? remain_down : delivered_r;
	wire [16:0] second = ctrl_r[`CTRL_SEC_SEL] ? grand_r : batches_r;

	always @* begin
		rd_nxt = 32'h0;
		case (haddr[7:0])
			`REG_CTRL: rd_nxt = {25'h0, ctrl_r};
			`REG_SCALE: rd_nxt = {12'h0, scale_r};
			`REG_PRESET_A: rd_nxt = {15'h0, preset_a_r};
			`REG_PRESET_B: rd_nxt = {15'h0, preset_b_r};
			`REG_PREWARN: rd_nxt = {15'h0, prewarn_r};
			`REG_ONTIME: rd_nxt = {18'h0, ontime_r};
			`REG_RATE_WIN: rd_nxt = {27'h0, win_r};
			`REG_LOCK: rd_nxt = {14'h0, lock_open_r, 17'h0};
			`REG_ACCESS: rd_nxt = {31'h0, remote_r};
			`REG_STATUS: rd_nxt = {25'h0, rate_dp_r, locked, done_r, running_r, relay_aux_r, relay_batch_r};
			`REG_AMOUNT: rd_nxt = {15'h0, amount};
			`REG_SECOND: rd_nxt = {15'h0, second};
			`REG_RATE: rd_nxt = {15'h0, rate_r};
			`REG_SERIAL: rd_nxt = {19'h0, serial_r};
			default: rd_nxt = 32'h0;
		endcase
	end

	// register writes land in the data phase; out-of-range values are dropped whole, control words are not range-checked
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_r <= 32'h0;
			hreadyout_r <= 1'b1;
			hresp_r <= 1'b0;
			wr_pend_r <= 1'b0;
			wa_r <= 8'h00;
			ctrl_r <= `CTRL_RST;
			scale_r <= `SCALE_RST;
			preset_a_r <= 17'h0;
			preset_b_r <= 17'h0;
			prewarn_r <= 17'h0;
			ontime_r <= 14'h0;
			win_r <= `WIN_RST;
			lock_code_r <= 17'h0;
			lock_open_r <= 1'b0;
			unlocked_r <= 1'b0;
			remote_r <= 1'b0;
			serial_r <= `SER_RST;
			nv_store_r <= 1'b0;
			nv_cfg_out_r <= `SER_RST;
		end else begin
			hreadyout_r <= 1'b1;
			hresp_r <= 1'b0;
			nv_store_r <= 1'b0;
			nv_cfg_out_r <= serial_r;
			wr_pend_r <= acc & hwrite;
			if (acc) wa_r <= haddr[7:0];
			if (acc && !hwrite) hrdata_r <= rd_nxt;
			if (nv_load) serial_r <= nv_cfg_in;
			if (wr_pend_r) begin
				case (wa_r)
					`REG_CTRL: if (cfg_ok) ctrl_r <= hwdata[`CTRL_W-1:0];
					`REG_SCALE:
						if (cfg_ok && hwdata[16:0] != 17'h0 && hwdata[16:0] <= `VAL_MAX &&
							hwdata[`SCALE_DP_HI:`SCALE_DP_LO] <= `DP_MAX)
							scale_r <= hwdata[19:0];
					`REG_PRESET_A: if (set_ok && hwdata[16:0] <= `VAL_MAX) preset_a_r <= hwdata[16:0];
					`REG_PRESET_B: if (set_ok && hwdata[16:0] <= `VAL_MAX) preset_b_r <= hwdata[16:0];
					`REG_PREWARN: if (set_ok && hwdata[16:0] <= `VAL_MAX) prewarn_r <= hwdata[16:0];
					`REG_ONTIME: if (set_ok && hwdata[13:0] <= `ONTIME_MAX) ontime_r <= hwdata[13:0];
					`REG_RATE_WIN:
						if (cfg_ok && hwdata[4:0] >= `WIN_MIN && hwdata[4:0] <= `WIN_MAX)
							win_r <= hwdata[4:0];
					`REG_LOCK:
						if (cfg_ok) begin
							lock_code_r <= hwdata[16:0];
							lock_open_r <= hwdata[`LOCK_OPEN_BIT];
							unlocked_r <= 1'b0;
						end
					`REG_UNLOCK: unlocked_r <= (hwdata[16:0] == lock_code_r);
					`REG_ACCESS: remote_r <= hwdata[0];
					`REG_SERIAL:
						if (cfg_ok && hwdata[`SER_ADDR_HI:0] >= `ADDR_MIN && hwdata[`SER_ADDR_HI:0] <= `ADDR_MAX &&
							hwdata[`SER_BAUD_HI:`SER_BAUD_LO] <= `BAUD_MAX &&
							hwdata[`SER_PAR_HI:`SER_PAR_LO] <= `PAR_MAX) begin
							serial_r <= hwdata[`SER_W-1:0];
							nv_store_r <= 1'b1;
						end
					default: ;
				endcase
			end
		end
	end

	// scaling: each pulse adds 10^dp, every whole divisor taken out is one unit
	// one unit per cycle, so a tiny divisor at high pulse rates lags before it drains
	wire unit_tick = (residue_r >= sdiv);
	wire [16:0] res_add = rise[0] ? pow10(sdp) : 17'h0;
	wire [16:0] res_sub = unit_tick ? sdiv : 17'h0;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			residue_r <= 17'h0;
		else
			residue_r <= residue_r + res_add - res_sub;
	end

	// batch sequencing and aux relay
	wire start_ok = rise[1] & ~filt_r[2] & ~filt_r[3];
	wire [16:0] del_inc = (unit_tick && delivered_r != `VAL_MAX) ? delivered_r + 17'h1 : delivered_r;
	wire complete = running_r & (del_inc >= preset_a_r);
	wire [16:0] remain = complete ? 17'h0 : preset_a_r - del_inc;
	wire [16:0] bc_inc = batches_r + 17'h1;
	wire [16:0] gt_inc = grand_r + 17'h1;
	wire fire_bc = complete & (aux_mode == `AUX_BATCHES) & (bc_inc >= preset_b_r);
	wire fire_gt = running_r & unit_tick & (aux_mode == `AUX_GRAND) & (gt_inc >= preset_b_r);
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			running_r <= 1'b0;
			done_r <= 1'b0;
			relay_batch_r <= 1'b0;
			relay_aux_r <= 1'b0;
			delivered_r <= 17'h0;
			batches_r <= 17'h0;
			grand_r <= 17'h0;
			aux_tmr_r <= 14'h0;
			step_cnt_r <= 18'h0;
		end else begin
			// timed aux output counts down in 10 ms steps
			if (aux_tmr_r != 14'h0) begin
				if (step_cnt_r == STEP_LAST) begin
					step_cnt_r <= 18'h0;
					aux_tmr_r <= aux_tmr_r - 14'h1;
					if (aux_tmr_r == 14'h1) relay_aux_r <= 1'b0;
				end else
					step_cnt_r <= step_cnt_r + 18'h1;
			end
			if (running_r) begin
				delivered_r <= del_inc;
				if (unit_tick) grand_r <= gt_inc;
				if (complete) begin
					running_r <= 1'b0;
					relay_batch_r <= 1'b0;
					done_r <= 1'b1;
					batches_r <= bc_inc;
				end
				if (aux_mode == `AUX_PREWARN && remain <= prewarn_r) relay_aux_r <= 1'b0;
			end
			if (fire_bc || fire_gt) begin
				relay_aux_r <= 1'b1;
				if (ontime_r != 14'h0) begin
					aux_tmr_r <= ontime_r;
					step_cnt_r <= 18'h0;
					if (fire_bc) batches_r <= 17'h0;
					else grand_r <= 17'h0;
				end
			end
			if (rise[2]) begin
				if (running_r) begin
					running_r <= 1'b0;
					relay_batch_r <= 1'b0;
					if (aux_mode == `AUX_PREWARN) relay_aux_r <= 1'b0;
				end else begin
					delivered_r <= 17'h0;
					done_r <= 1'b0;
					relay_aux_r <= 1'b0;
					aux_tmr_r <= 14'h0;
				end
			end else if (rise[3]) begin
				if (running_r) begin
					running_r <= 1'b0;
					relay_batch_r <= 1'b0;
					if (aux_mode == `AUX_PREWARN) relay_aux_r <= 1'b0;
				end else begin
					delivered_r <= 17'h0;
					done_r <= 1'b0;
				end
			end else if (start_ok && !running_r) begin
				running_r <= 1'b1;
				relay_batch_r <= 1'b1;
				if (done_r) begin
					delivered_r <= 17'h0;
					done_r <= 1'b0;
				end
				if (aux_mode == `AUX_PREWARN) relay_aux_r <= 1'b1;
			end
		end
	end

	// per-second unit counts kept in a ring; the window sum drops the oldest entry
	wire sec_tick = (sec_cnt_r == SEC_LAST);
	wire [4:0] old_idx = (ptr_r >= win_r) ? ptr_r - win_r : ptr_r + 5'd24 - win_r;
	wire [16:0] old_val = (fill_r >= win_r) ? ring[old_idx] : 17'h0;
	always @(posedge hclk) begin
		if (sec_tick) ring[ptr_r] <= cur_cnt_r;
	end

	always @* begin
		case (ctrl_r[`CTRL_RU_HI:`CTRL_RU_LO])
			`RU_MIN: mult = `MULT_MIN;
			`RU_HOUR: mult = `MULT_HOUR;
			default: mult = `MULT_SEC;
		endcase
	end

	// rate in hundredths, divided by window; the divisor grows tenfold, at most twice, while over five digits
	wire [21:0] sum_nxt = sum_r + {5'h0, cur_cnt_r} - {5'h0, old_val};
	wire [41:0] num_nxt = sum_nxt * mult * `HUNDRED;
	wire [12:0] rs = {rem_r[11:0], quo_r[41]};
	wire rge = (rs >= {1'b0, dvs_r});
	wire [41:0] q_fin = {quo_r[40:0], rge};
	wire [14:0] dvs_x10 = {dvs_r[11:0], 3'h0} + {2'h0, dvs_r[11:0], 1'b0};
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sec_cnt_r <= 25'h0;
			cur_cnt_r <= 17'h0;
			ptr_r <= 5'h0;
			fill_r <= 5'h0;
			sum_r <= 22'h0;
			rs_r <= RS_IDLE;
			num_r <= 42'h0;
			quo_r <= 42'h0;
			rem_r <= 13'h0;
			dvs_r <= 12'h0;
			dstep_r <= 6'h0;
			rk_r <= 2'h0;
			rate_r <= 17'h0;
			rate_dp_r <= 2'h2;
		end else begin
			sec_cnt_r <= sec_tick ? 25'h0 : sec_cnt_r + 25'h1;
			if (sec_tick)
				cur_cnt_r <= unit_tick ? 17'h1 : 17'h0;
			else if (unit_tick && cur_cnt_r != `VAL_MAX)
				cur_cnt_r <= cur_cnt_r + 17'h1;
			if (wr_pend_r && wa_r == `REG_RATE_WIN) begin
				fill_r <= 5'h0; // window change restarts the average
				sum_r <= 22'h0;
			end else if (sec_tick) begin
				ptr_r <= (ptr_r == 5'd23) ? 5'h0 : ptr_r + 5'h1;
				if (fill_r < `WIN_MAX) fill_r <= fill_r + 5'h1;
				sum_r <= sum_nxt;
			end
			case (rs_r)
				RS_IDLE:
					if (sec_tick) begin
						num_r <= num_nxt;
						quo_r <= num_nxt;
						rem_r <= 13'h0;
						dvs_r <= {7'h0, win_r};
						dstep_r <= `DIV_STEPS;
						rk_r <= 2'h0;
						rs_r <= RS_DIV;
					end
				RS_DIV: begin
					quo_r <= q_fin;
					rem_r <= rge ? rs - {1'b0, dvs_r} : rs;
					dstep_r <= dstep_r - 6'h1;
					if (dstep_r == 6'h1) begin
						if (q_fin > {25'h0, `VAL_MAX} && rk_r != `RANGE_MAX) begin
							rk_r <= rk_r + 2'h1;
							dvs_r <= dvs_x10[11:0];
							quo_r <= num_r;
							rem_r <= 13'h0;
							dstep_r <= `DIV_STEPS;
						end else begin
							rate_r <= (q_fin > {25'h0, `VAL_MAX}) ? `VAL_MAX : q_fin[16:0];
							rate_dp_r <= `RANGE_MAX - rk_r;
							rs_r <= RS_IDLE;
						end
					end
				end
				default: rs_r <= RS_IDLE;
			endcase
		end
	end

	// analog value source
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			analog_value_r <= 17'h0;
		else
			analog_value_r <= ctrl_r[`CTRL_AN_SRC] ? amount : rate_r;
	end
endmodule // pulse_batch_controller

// File: tb/field_side.sv
// field_side.sv: flow sensor and panel/remote buttons facing the controller pins
// assumes the bench calls its tasks from the controller clock domain
`timescale 1ns/10ps

module field_side (
	// clock
	input wire hclk,
	// pins toward the controller
	output wire pulse_in,
	output wire start_in,
	output wire stop_front_in,
	output wire stop_remote_in
);
	logic [3:0] pins = 4'h0;

	// idle low between actions; sensor and switches have no free-running activity
	assign {stop_remote_in, stop_front_in, start_in, pulse_in} = pins;

	// one pin moves just after an edge, never twice in a time step
	task automatic drive(input int which, input logic v);
		@(posedge hclk);
		pins[which] <= v;
	endtask

	// each press stays high six edges so the input filter accepts it, then idles as long
	task automatic press(input int which, input int n);
		repeat (n) begin
			drive(which, 1'b1);
			repeat (5) @(posedge hclk);
			drive(which, 1'b0);
			repeat (5) @(posedge hclk);
		end
	endtask
endmodule // field_side

// File: tb/pulse_batch_properties.sv
// pulse_batch_properties.sv: port-level checker for the batch controller
// assumes binding into the controller; sees only its ports
`timescale 1ns/10ps

module pulse_batch_properties (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// bus
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hwdata,
	input wire hready,
	input wire [31:0] hrdata_r,
	input wire hreadyout_r,
	input wire hresp_r,
	// pins and outputs
	input wire start_in,
	input wire stop_front_in,
	input wire stop_remote_in,
	input wire relay_batch_r,
	input wire nv_load,
	input wire [12:0] nv_cfg_in,
	input wire [12:0] nv_cfg_out_r,
	input wire nv_store_r
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_resp_okay; hresp_r == 1'b0 && hreadyout_r == 1'b1; endproperty
	a_resp_okay: assert property (p_resp_okay) else $error("bus answer not zero-wait okay");
	property p_read_zero; hsel && htrans[1] && hready && !hwrite
		&& (haddr[7:0] == 8'h20 || haddr[7:0] > 8'h38) |=> hrdata_r == 32'h0; endproperty
	a_read_zero: assert property (p_read_zero) else $error("hidden or unmapped word read nonzero");
	// the lock word shows only its open-presets flag, never the code
	property p_lock_hidden; hsel && htrans[1] && hready && !hwrite && haddr[7:0] == 8'h1C
		|=> hrdata_r[16:0] == 17'h0 && hrdata_r[31:18] == 14'h0; endproperty
	a_lock_hidden: assert property (p_lock_hidden) else $error("lock code readable");
	property p_front_halt; $rose(stop_front_in) |-> ##6 !relay_batch_r; endproperty
	a_front_halt: assert property (p_front_halt) else $error("front stop left batch relay on");
	property p_remote_halt; $rose(stop_remote_in) |-> ##6 !relay_batch_r; endproperty
	a_remote_halt: assert property (p_remote_halt) else $error("remote stop left batch relay on");
	// a held stop has long passed the filter, so no start may land
	property p_inhibit; (stop_front_in || stop_remote_in) [*8] |-> !$rose(relay_batch_r); endproperty
	a_inhibit: assert property (p_inhibit) else $error("start taken while stop held");
	property p_start_cause; $rose(relay_batch_r) |-> $past(start_in, 4); endproperty
	a_start_cause: assert property (p_start_cause) else $error("batch relay rose without start");
	property p_cfg_range; nv_cfg_out_r[7:0] >= 8'h01 && nv_cfg_out_r[7:0] <= 8'hF7
		&& nv_cfg_out_r[10:8] <= 3'h5 && nv_cfg_out_r[12:11] <= 2'h2; endproperty
	a_cfg_range: assert property (p_cfg_range) else $error("serial settings out of range");
	property p_nv_restore; nv_load |-> ##2 nv_cfg_out_r == $past(nv_cfg_in, 2); endproperty
	a_nv_restore: assert property (p_nv_restore) else $error("stored settings not restored");
	property p_store_pulse; nv_store_r |=> !nv_store_r; endproperty
	a_store_pulse: assert property (p_store_pulse) else $error("store strobe longer than a cycle");
	// a write of unit address zero must never reach storage
	property p_bad_store; hsel && htrans[1] && hready && hwrite && haddr[7:0] == 8'h38
		##1 hwdata[7:0] == 8'h00 |-> !nv_store_r [*3]; endproperty
	a_bad_store: assert property (p_bad_store) else $error("invalid serial write stored");
endmodule // pulse_batch_properties

bind pulse_batch_controller pulse_batch_properties i_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata_r(hrdata_r),
	.hreadyout_r(hreadyout_r), .hresp_r(hresp_r), .start_in(start_in), .stop_front_in(stop_front_in),
	.stop_remote_in(stop_remote_in), .relay_batch_r(relay_batch_r), .nv_load(nv_load),
	.nv_cfg_in(nv_cfg_in), .nv_cfg_out_r(nv_cfg_out_r), .nv_store_r(nv_store_r));

// File: tb/pulse_batch_controller_tb.sv
// pulse_batch_controller_tb.sv: self-checking bench for the batch controller
// assumes controller, constants header, field model and checker compiled first
`timescale 1ns/10ps
`include "pulse_batch_consts.vh"

module pulse_batch_controller_tb;
	localparam int STEP = 10;
	localparam int PULSE = 0;
	localparam int START = 1;
	localparam int FRONT = 2;
	localparam int REMOTE = 3;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic nv_load = 1'b0;
	logic [12:0] nv_cfg_in = 13'h0000;
	logic [31:0] q;
	wire hready;
	wire [31:0] hrdata_r;
	wire hresp_r;
	wire pulse_in;
	wire start_in;
	wire stop_front_in;
	wire stop_remote_in;
	wire relay_batch_r;
	wire relay_aux_r;
	wire [16:0] analog_value_r;
	wire [12:0] nv_cfg_out_r;
	wire nv_store_r;
	int fail_count = 0;
	int checks_done = 0;

	// short second and on-time step keep the run brief
	pulse_batch_controller #(.SEC_CYCLES(200), .STEP_CYCLES(STEP)) i_dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata_r(hrdata_r), .hreadyout_r(hready), .hresp_r(hresp_r), .pulse_in(pulse_in),
		.start_in(start_in), .stop_front_in(stop_front_in), .stop_remote_in(stop_remote_in),
		.relay_batch_r(relay_batch_r), .relay_aux_r(relay_aux_r), .analog_value_r(analog_value_r),
		.nv_load(nv_load), .nv_cfg_in(nv_cfg_in), .nv_cfg_out_r(nv_cfg_out_r), .nv_store_r(nv_store_r));

	field_side i_field (.hclk(hclk), .pulse_in(pulse_in), .start_in(start_in), .stop_front_in(stop_front_in),
		.stop_remote_in(stop_remote_in));

	initial forever #20 hclk = ~hclk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// single word transfer; entered just after an edge, waits on hready, no fixed latency
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata_r;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'b1, a, d);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask

	task automatic run_batch;
		i_field.press(START, 1);
		i_field.press(PULSE, 3);
	endtask

	task automatic t_reset;
		ahb(1'b0, `REG_STATUS, 32'h0);
		chk(q[4:0], 5'h00);
		rchk(`REG_SCALE, 32'h1);
		rchk(`REG_RATE_WIN, 32'h2);
		rchk(`REG_SERIAL, 32'h501);
		rchk(`REG_LOCK, 32'h0);
		rchk(8'h3C, 32'h0);
	endtask

	// divisor 0.5 gives two units a pulse; preset 6 completes on the third pulse
	task automatic t_batch;
		wr(`REG_SCALE, 32'h0002_0005);
		wr(`REG_PRESET_A, 32'h6);
		i_field.press(START, 1);
		chk(relay_batch_r, 1);
		i_field.press(PULSE, 2);
		rchk(`REG_AMOUNT, 32'h4);
		chk(relay_batch_r, 1);
		i_field.press(PULSE, 1);
		chk(relay_batch_r, 0);
		rchk(`REG_AMOUNT, 32'h6);
		ahb(1'b0, `REG_STATUS, 32'h0);
		chk(q[4:0], 5'h08);
		rchk(`REG_SECOND, 32'h1);
	endtask

	task automatic t_stop;
		i_field.press(START, 1);
		i_field.press(PULSE, 1);
		i_field.press(FRONT, 1);
		chk(relay_batch_r, 0);
		rchk(`REG_AMOUNT, 32'h2);
		i_field.press(START, 1);
		i_field.press(REMOTE, 1);
		chk(relay_batch_r, 0);
		rchk(`REG_AMOUNT, 32'h2);
		i_field.press(REMOTE, 1);
		rchk(`REG_AMOUNT, 32'h0);
		i_field.drive(FRONT, 1'b1);
		repeat (8) @(posedge hclk);
		i_field.press(START, 1);
		chk(relay_batch_r, 0);
		i_field.drive(FRONT, 1'b0);
		repeat (6) @(posedge hclk);
	endtask

	task automatic t_down;
		wr(`REG_CTRL, 32'h1);
		i_field.press(START, 1);
		i_field.press(PULSE, 1);
		rchk(`REG_AMOUNT, 32'h4);
		i_field.press(FRONT, 2);
		wr(`REG_CTRL, 32'h0);
	endtask

	task automatic t_prewarn;
		wr(`REG_PREWARN, 32'h2);
		i_field.press(START, 1);
		chk(relay_aux_r, 1);
		i_field.press(PULSE, 1);
		chk(relay_aux_r, 1);
		i_field.press(PULSE, 1);
		chk(relay_aux_r, 0);
		chk(relay_batch_r, 1);
		i_field.press(PULSE, 1);
	endtask

	// batches counter stands at 2 here; grand total at 16 units
	task automatic t_count;
		wr(`REG_CTRL, 32'h2);
		wr(`REG_PRESET_B, 32'h4);
		wr(`REG_ONTIME, 32'h3);
		run_batch();
		chk(relay_aux_r, 0);
		rchk(`REG_SECOND, 32'h3);
		run_batch();
		chk(relay_aux_r, 1);
		rchk(`REG_SECOND, 32'h0);
		repeat (4 * STEP) @(posedge hclk);
		chk(relay_aux_r, 0);
		wr(`REG_ONTIME, 32'h0);
		wr(`REG_PRESET_B, 32'h1);
		run_batch();
		repeat (4 * STEP) @(posedge hclk);
		chk(relay_aux_r, 1);
		rchk(`REG_SECOND, 32'h1);
		i_field.press(FRONT, 1);
		chk(relay_aux_r, 0);
		wr(`REG_CTRL, 32'hC);
		rchk(`REG_SECOND, 32'd34);
		wr(`REG_PRESET_B, 32'd36);
		run_batch();
		chk(relay_aux_r, 1);
		wr(`REG_CTRL, 32'h40);
		repeat (2) @(posedge hclk);
		chk(analog_value_r, 32'h6);
	endtask

	task automatic t_remote;
		wr(`REG_ACCESS, 32'h1);
		wr(`REG_CTRL, 32'h0);
		rchk(`REG_CTRL, 32'h40);
		wr(`REG_PRESET_A, 32'h9);
		rchk(`REG_PRESET_A, 32'h9);
		wr(`REG_ACCESS, 32'h0);
		wr(`REG_LOCK, 32'h123);
		ahb(1'b0, `REG_STATUS, 32'h0);
		chk(q[4], 1);
		wr(`REG_PRESET_A, 32'h7);
		rchk(`REG_PRESET_A, 32'h9);
		wr(`REG_UNLOCK, 32'h123);
		wr(`REG_PRESET_A, 32'h7);
		rchk(`REG_PRESET_A, 32'h7);
		// lock with presets left open: preset edits pass, mode edits do not
		wr(`REG_LOCK, 32'h2_0456);
		rchk(`REG_LOCK, 32'h2_0000);
		wr(`REG_PRESET_A, 32'h5);
		rchk(`REG_PRESET_A, 32'h5);
		wr(`REG_CTRL, 32'h1);
		rchk(`REG_CTRL, 32'h40);
		wr(`REG_UNLOCK, 32'h456);
	endtask

	task automatic t_serial;
		wr(`REG_SERIAL, 32'h15F7);
		@(posedge hclk);
		chk(nv_store_r, 1'b1);
		rchk(`REG_SERIAL, 32'h15F7);
		chk(nv_cfg_out_r, 32'h15F7);
		wr(`REG_SERIAL, 32'h00F8);
		rchk(`REG_SERIAL, 32'h15F7);
		wr(`REG_SERIAL, 32'h0601);
		rchk(`REG_SERIAL, 32'h15F7);
		wr(`REG_SERIAL, 32'h0500);
		@(posedge hclk);
		chk(nv_store_r, 1'b0);
		rchk(`REG_SERIAL, 32'h15F7);
		nv_cfg_in <= 13'h0A05;
		nv_load <= 1'b1;
		@(posedge hclk);
		nv_load <= 1'b0;
		@(posedge hclk);
		rchk(`REG_SERIAL, 32'hA05);
	endtask

	// sixty units inside a fresh 24 s window; a quiet second first keeps old units out
	task automatic t_rate;
		wr(`REG_SCALE, 32'h0004_0005);
		wr(`REG_CTRL, 32'h20);
		repeat (200) @(posedge hclk);
		wr(`REG_RATE_WIN, 32'd24);
		i_field.press(PULSE, 3);
		repeat (600) @(posedge hclk);
		rchk(`REG_RATE, 32'h15F90);
		ahb(1'b0, `REG_STATUS, 32'h0);
		chk(q[6:5], 2'h1);
		chk(analog_value_r, 32'h15F90);
		wr(`REG_CTRL, 32'h10);
		repeat (400) @(posedge hclk);
		rchk(`REG_RATE, 32'h3A98);
		ahb(1'b0, `REG_STATUS, 32'h0);
		chk(q[6:5], 2'h2);
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// main sequence after two cycles of reset
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_batch();
		t_stop();
		t_down();
		t_prewarn();
		t_count();
		t_remote();
		t_serial();
		t_rate();
		final_report();
	end

	// watchdog well beyond the few thousand cycles the sequence needs
	initial begin
		#800000;
		fail_count++;
		final_report();
	end
endmodule // pulse_batch_controller_tb
